// [hw/acs_cal_sequencer.sv]
// Purpose: Calibration sequencer and result correction for a sigma-delta converter.
// Assumes: raw_word_i is the signed filter word for the current front-end selection.
// Notes: Full-scale results are stored as a normalised gain from a serial divider.
//
// What this block does, and what its host must do
// [R1] Code 001 runs zero then full scale
// [R2] Self zero-scale shorts inputs to bias
// [R3] Self full-scale converts reference over gain
// [R4] Full self-calibration takes six periods
// [R5] Mode code clears to 000 at end
// [R6] Ready held high from start until word
// [R7] Full self-calibration ready after nine periods
// [R8] Ready rises within one modulator cycle
// [R9] Host ignores ready one modulator cycle
// [R10] Bipolar zero input gives 800000 hex
// [R11] Codes 110/111 run single self steps
// [R12] Single self step three, ready six
// [R13] Host avoids full-scale without zero-scale
// [R14] Single step updates only its coefficient
// [R15] Code 010 zero-scale on external input
// [R16] Host holds calibration voltage stable
// [R17] System zero-scale three, ready four
// [R18] Code 011 full-scale on external input
// [R19] System full-scale three, ready four
// [R20] Bipolar span is midscale to full
// [R21] Results go to selected channel coefficients
// [R22] Subtract offset, then multiply by gain
// [R23] Output period is 128 times filter word
// [R24] Code 000 means normal conversions
//
// Added by the designer: the register offsets and the address-and-strobe port.

`timescale 1ns/1ps

module acs_cal_sequencer (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [23:0] raw_word_i,
  output logic [31:0] rd_data_o,
  output logic data_ready_n_o,
  output logic [1:0] fe_sel_o,
  output logic [2:0] gain_select_field_o,
  output logic [1:0] chan_sel_o
);
  import acs_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acs_state_t st_q, st_d;
  logic [1:0] step_q, step_d;            // Periods done in current step
  logic [2:0] code_q, code_d;            // Visible calibration mode code
  logic [2:0] op_q, op_d;                // Calibration being run
  logic pend_q, pend_d;                  // Command waits for modulator edge
  logic bip_q, bip_d;                    // Bipolar range
  logic [2:0] gain_q, gain_d;
  logic [1:0] chan_q, chan_d;
  logic [11:0] filt_q, filt_d;
  logic [23:0] word_q, word_d;           // Data register
  logic data_ready_n_n_q, data_ready_n_n_d;
  logic [1:0] fe_q, fe_d;
  logic [31:0] rdat_q, rdat_d;
  logic [23:0] zs_mem_q [4], zs_mem_d [4];
  logic [25:0] gn_mem_q [4], gn_mem_d [4];
  // Serial divider for the gain coefficient
  logic div_busy_q, div_busy_d;
  logic [5:0] div_cnt_q, div_cnt_d;
  logic [23:0] div_den_q, div_den_d;
  logic [24:0] div_rem_q, div_rem_d;
  logic [25:0] div_quo_q, div_quo_d;
  logic div_ovf_q, div_ovf_d;
  logic [1:0] div_ch_q, div_ch_d;
  // Combinational helpers
  logic mod_tick, period_tick, start, wr_mode, full_op, self_op, sys_op;
  logic word_load, cal_end, post_done;
  logic [1:0] post_last;
  logic [24:0] diff, div_sh;
  logic [51:0] prod;
  logic [28:0] scaled;
  logic [29:0] outv;
  logic [23:0] corr;
  logic [3:0] per_since_q, per_since_d; // Periods since start, for checks only

  // ----------------------------------------------------------------
  // Output-rate timing
  // ----------------------------------------------------------------
  acs_rate_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .restart_i(start),
    .filter_word_i(filt_q),
    .mod_tick_o(mod_tick),
    .period_tick_o(period_tick)
  );

  // ----------------------------------------------------------------
  // Correction datapath
  // ----------------------------------------------------------------
  // Offset first, then gain; clamps keep the code inside 24 bits
  always_comb begin
    diff = $signed({raw_word_i[23], raw_word_i}) - $signed({zs_mem_q[chan_q][23], zs_mem_q[chan_q]}); // [R22]
    prod = $signed(diff) * $signed({1'h0, gn_mem_q[chan_q]}); // [R22]
    scaled = prod[51:PROD_LSB];
    if (bip_q) begin
      outv = $signed({scaled[28], scaled}) + $signed({6'h00, BIPOLAR_MID}); // [R10] [R20]
    end else begin
      outv = {scaled, 1'h0}; // Unipolar span covers the whole code range
    end
    if (outv[29]) begin
      corr = 24'h000000;
    end else if (outv[28:24] != 5'h00) begin
      corr = CODE_MAX;
    end else begin
      corr = outv[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Sequencer, registers and divider: next values
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    step_d = step_q;
    code_d = code_q;
    op_d = op_q;
    pend_d = pend_q;
    bip_d = bip_q;
    gain_d = gain_q;
    chan_d = chan_q;
    filt_d = filt_q;
    word_d = word_q;
    data_ready_n_n_d = data_ready_n_n_q;
    zs_mem_d = zs_mem_q;
    gn_mem_d = gn_mem_q;
    div_busy_d = div_busy_q;
    div_cnt_d = div_cnt_q;
    div_den_d = div_den_q;
    div_rem_d = div_rem_q;
    div_quo_d = div_quo_q;
    div_ovf_d = div_ovf_q;
    div_ch_d = div_ch_q;
    word_load = 1'h0;
    cal_end = 1'h0;
    post_done = 1'h0;
    full_op = (op_q == CAL_SELF_FULL); // [R1]
    self_op = (op_q == CAL_SELF_FULL) || (op_q == CAL_SELF_ZS) || (op_q == CAL_SELF_FS);
    sys_op = (op_q == CAL_SYS_ZS) || (op_q == CAL_SYS_FS);
    post_last = sys_op ? POST_SYS_LAST : POST_SELF_LAST; // [R12] [R17] [R19]
    wr_mode = wr_en_i && (addr_i == ADDR_MODE);
    // Start waits for a modulator edge so periods line up with it
    start = pend_q && mod_tick; // [R8]
    if (start) begin
      st_d = ((op_q == CAL_SELF_FS) || (op_q == CAL_SYS_FS)) ? ST_FS : ST_ZS; // [R11] [R15] [R18]
      step_d = 2'h0;
      pend_d = 1'h0;
      data_ready_n_n_d = 1'h1; // [R6] [R8]
    end else if (period_tick) begin
      unique case (st_q)
        ST_NORM: begin
          // Normal conversions only when no command waits
          if (!pend_q) begin
            word_load = 1'h1; // [R24]
          end
        end
        ST_ZS: begin
          if (step_q == STEP_LAST) begin
            zs_mem_d[chan_q] = raw_word_i; // [R21] [R14]
            step_d = 2'h0;
            if (full_op) begin
              st_d = ST_FS; // [R1] [R4]
            end else begin
              st_d = ST_POST;
              code_d = CAL_NORMAL; // [R5]
              cal_end = 1'h1;
            end
          end else begin
            step_d = step_q + 2'h1;
          end
        end
        ST_FS: begin
          if (step_q == STEP_LAST) begin
            // Gain becomes 2^46 over the measured span
            div_busy_d = 1'h1; // [R21]
            div_cnt_d = DIV_STEPS;
            div_den_d = (diff[24] || (diff == 25'h0000000)) ? 24'h000001 : diff[23:0];
            div_rem_d = 25'h0000000;
            div_quo_d = 26'h0000000;
            div_ovf_d = 1'h0;
            div_ch_d = chan_q;
            step_d = 2'h0;
            st_d = ST_POST;
            code_d = CAL_NORMAL; // [R5]
            cal_end = 1'h1;
          end else begin
            step_d = step_q + 2'h1;
          end
        end
        ST_POST: begin
          if (step_q == post_last) begin
            word_load = 1'h1; // [R7] [R12] [R17] [R19]
            post_done = 1'h1;
            st_d = ST_NORM; // [R24]
          end else begin
            step_d = step_q + 2'h1;
          end
        end
      endcase
    end
    // Divider: one quotient bit per clock, done long before the next word
    div_sh = {div_rem_q[23:0], (div_cnt_q == DIV_STEPS)};
    if (div_busy_q) begin
      if (div_sh >= {1'h0, div_den_q}) begin
        div_rem_d = div_sh - {1'h0, div_den_q};
        div_quo_d = {div_quo_q[24:0], 1'h1};
      end else begin
        div_rem_d = div_sh;
        div_quo_d = {div_quo_q[24:0], 1'h0};
      end
      div_ovf_d = div_ovf_q || div_quo_q[25];
      div_cnt_d = div_cnt_q - 6'h01;
      if (div_cnt_q == 6'h00) begin
        div_busy_d = 1'h0;
        gn_mem_d[div_ch_q] = (div_ovf_q || div_quo_q[25]) ? {26{1'h1}} : div_quo_d; // [R14]
      end
    end
    // New word pulls ready low; set wins over a same-cycle read
    if (word_load) begin
      word_d = corr;
      data_ready_n_n_d = 1'h0;
    end else if (rd_en_i && (addr_i == ADDR_DATA)) begin
      data_ready_n_n_d = 1'h1;
    end
    // Register writes
    if (wr_mode) begin
      gain_d = wr_data_i[MODE_GAIN_LSB +: 3]; // [R2] [R3]
      chan_d = wr_data_i[MODE_CHAN_LSB +: 2];
      bip_d = wr_data_i[MODE_BIPOLAR_BIT];
      unique case (wr_data_i[MODE_CODE_LSB +: 3])
        CAL_NORMAL: begin
          // Aborts any calibration in progress
          code_d = CAL_NORMAL;
          pend_d = 1'h0;
          st_d = ST_NORM;
        end
        CAL_SELF_FULL, CAL_SYS_ZS, CAL_SYS_FS, CAL_SELF_ZS, CAL_SELF_FS: begin
          // A new command restarts from the next modulator edge
          code_d = wr_data_i[MODE_CODE_LSB +: 3];
          op_d = wr_data_i[MODE_CODE_LSB +: 3];
          pend_d = 1'h1;
          st_d = ST_NORM;
        end
        default: begin
          // Unsupported codes leave the mode code as it was
          code_d = code_q;
        end
      endcase
    end
    if (wr_en_i && (addr_i == ADDR_FILTER)) begin
      filt_d = wr_data_i[11:0];
    end
    // Front end follows the next state
    if ((st_d == ST_ZS) && self_op_next(op_d)) begin
      fe_d = FE_BIAS; // [R2]
    end else if ((st_d == ST_FS) && self_op_next(op_d)) begin
      fe_d = FE_REF; // [R3]
    end else begin
      fe_d = FE_INPUT; // [R15] [R18]
    end
    // Read data stands only in the cycle after the strobe
    rdat_d = 32'h00000000;
    if (rd_en_i) begin
      unique case (addr_i)
        ADDR_MODE: rdat_d = {23'h000000, bip_q, chan_q, gain_q, code_q};
        ADDR_FILTER: rdat_d = {20'h00000, filt_q};
        ADDR_DATA: rdat_d = {8'h00, word_q};
        ADDR_STATUS: rdat_d = {29'h00000000, pend_q, (st_q != ST_NORM), data_ready_n_n_q};
        ADDR_ZS_COEF: rdat_d = {8'h00, zs_mem_q[chan_q]};
        ADDR_GAIN_COEF: rdat_d = {6'h00, gn_mem_q[chan_q]};
        default: rdat_d = 32'h00000000;
      endcase
    end
    // Period count since start, used by the checks
    per_since_d = per_since_q;
    if (start) begin
      per_since_d = 4'h0;
    end else if (period_tick && (per_since_q != 4'hF)) begin
      per_since_d = per_since_q + 4'h1;
    end
  end

  // Self-calibration test on the op that the next state will run
  function automatic logic self_op_next(input logic [2:0] op);
    self_op_next = (op == CAL_SELF_FULL) || (op == CAL_SELF_ZS) || (op == CAL_SELF_FS);
  endfunction

  // ----------------------------------------------------------------
  // Registers only
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= ST_NORM;
      step_q <= 2'h0;
      code_q <= CAL_NORMAL;
      op_q <= CAL_NORMAL;
      pend_q <= 1'h0;
      bip_q <= 1'h0;
      gain_q <= GAIN_SEL_RST;
      chan_q <= CHAN_RST;
      filt_q <= FILTER_RST;
      word_q <= 24'h000000;
      data_ready_n_n_q <= 1'h1;
      fe_q <= FE_INPUT;
      rdat_q <= 32'h00000000;
      for (int i = 0; i < 4; i++) begin
        zs_mem_q[i] <= ZS_RST;
        gn_mem_q[i] <= GAIN_RST;
      end
      div_busy_q <= 1'h0;
      div_cnt_q <= 6'h00;
      div_den_q <= 24'h000001;
      div_rem_q <= 25'h0000000;
      div_quo_q <= 26'h0000000;
      div_ovf_q <= 1'h0;
      div_ch_q <= 2'h0;
      per_since_q <= 4'h0;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      code_q <= code_d;
      op_q <= op_d;
      pend_q <= pend_d;
      bip_q <= bip_d;
      gain_q <= gain_d;
      chan_q <= chan_d;
      filt_q <= filt_d;
      word_q <= word_d;
      data_ready_n_n_q <= data_ready_n_n_d;
      fe_q <= fe_d;
      rdat_q <= rdat_d;
      zs_mem_q <= zs_mem_d;
      gn_mem_q <= gn_mem_d;
      div_busy_q <= div_busy_d;
      div_cnt_q <= div_cnt_d;
      div_den_q <= div_den_d;
      div_rem_q <= div_rem_d;
      div_quo_q <= div_quo_d;
      div_ovf_q <= div_ovf_d;
      div_ch_q <= div_ch_d;
      per_since_q <= per_since_d;
    end
  end

  assign rd_data_o = rdat_q;
  assign data_ready_n_o = data_ready_n_n_q;
  assign fe_sel_o = fe_q;
  assign gain_select_field_o = gain_q;
  assign chan_sel_o = chan_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  chk_start_ready_high: assert property (start |=> data_ready_n_o) // [R6]
    else $error("ready not high after calibration start");
  chk_ready_held_high: assert property ((st_q != ST_NORM) |-> data_ready_n_o) // [R6]
    else $error("ready low during calibration");
  chk_pending_bounded: assert property (pend_q |-> ##[0:128] !pend_q) // [R8]
    else $error("command not started within a modulator cycle");
  chk_zs_self_bias: assert property ((st_q == ST_ZS && self_op) |-> fe_sel_o == FE_BIAS) // [R2]
    else $error("self zero-scale not on bias");
  chk_fs_self_ref: assert property ((st_q == ST_FS && self_op) |-> fe_sel_o == FE_REF) // [R3]
    else $error("self full-scale not on reference");
  chk_cal_length: assert property (cal_end |-> per_since_q + 4'h1 == (full_op ? FULL_CAL_PERIODS : // [R4]
    ONE_STEP_PERIODS))
    else $error("calibration length wrong");
  chk_code_cleared: assert property ((cal_end && !wr_mode) |=> // [R5]
    code_q == CAL_NORMAL ##1 (code_q == CAL_NORMAL || $past(wr_en_i)))
    else $error("mode code not cleared");
  chk_ready_delay: assert property (post_done |-> per_since_q + 4'h1 == (full_op ? FULL_READY_PERIODS : // [R7]
    (sys_op ? SYS_READY_PERIODS : SELF_READY_PERIODS)))
    else $error("ready delay wrong");
  // A same-cycle mode write may move the channel, so the index would change under the check
  chk_zs_keeps_gain: assert property ((st_q == ST_ZS && cal_end && !div_busy_q && !wr_mode) |=> // [R14]
    $stable(gn_mem_q[chan_q]))
    else $error("zero-scale step changed gain");
  chk_bipolar_mid: assert property ((word_load && bip_q && diff == 25'h0000000) |=> word_q == BIPOLAR_MID) // [R10]
    else $error("bipolar zero not midscale");
  chk_normal_resume: assert property ((st_q == ST_NORM && period_tick && !pend_q && !start) |=> // [R24]
    !data_ready_n_o)
    else $error("normal conversion did not signal ready");

endmodule

// [hw/acs_pkg.sv]
// Purpose: Shared constants and types for the calibration sequencer.
// Assumes: 32-bit register port, one word per register, byte addresses.
// Notes: Coefficient defaults give unity correction until a calibration runs.

package acs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h00;      // Mode code, gain, channel, polarity
  localparam logic [7:0] ADDR_FILTER = 8'h04;    // Output-rate divider word
  localparam logic [7:0] ADDR_DATA = 8'h08;      // Latest corrected word
  localparam logic [7:0] ADDR_STATUS = 8'h0C;    // Ready, busy, pending
  localparam logic [7:0] ADDR_ZS_COEF = 8'h10;   // Zero-scale coefficient, selected channel
  localparam logic [7:0] ADDR_GAIN_COEF = 8'h14; // Normalised gain, selected channel

  // ----------------------------------------------------------------
  // Field positions in the mode and status registers
  // ----------------------------------------------------------------
  localparam int MODE_CODE_LSB = 0;
  localparam int MODE_GAIN_LSB = 3;
  localparam int MODE_CHAN_LSB = 6;
  localparam int MODE_BIPOLAR_BIT = 8;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_PEND_BIT = 2;

  // ----------------------------------------------------------------
  // Calibration mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CAL_NORMAL = 3'h0;
  localparam logic [2:0] CAL_SELF_FULL = 3'h1;
  localparam logic [2:0] CAL_SYS_ZS = 3'h2;
  localparam logic [2:0] CAL_SYS_FS = 3'h3;
  localparam logic [2:0] CAL_SELF_ZS = 3'h6;
  localparam logic [2:0] CAL_SELF_FS = 3'h7;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam logic [6:0] MOD_CNT_MAX = 7'h7F;     // Modulator cycle is 128 clocks
  localparam logic [1:0] STEP_LAST = 2'h2;        // Three periods per calibration step
  localparam logic [1:0] POST_SELF_LAST = 2'h2;   // Three-period input conversion
  localparam logic [1:0] POST_SYS_LAST = 2'h0;    // Single-period input conversion
  localparam logic [3:0] FULL_CAL_PERIODS = 4'h6;
  localparam logic [3:0] ONE_STEP_PERIODS = 4'h3;
  localparam logic [3:0] FULL_READY_PERIODS = 4'h9;
  localparam logic [3:0] SELF_READY_PERIODS = 4'h6;
  localparam logic [3:0] SYS_READY_PERIODS = 4'h4;
  localparam logic [5:0] DIV_STEPS = 6'h2E;       // Quotient bits 46 down to 0

  // ----------------------------------------------------------------
  // Front-end selections and code limits
  // ----------------------------------------------------------------
  localparam logic [1:0] FE_INPUT = 2'h0;         // External analog input pair
  localparam logic [1:0] FE_BIAS = 2'h1;          // Both inputs shorted to bias
  localparam logic [1:0] FE_REF = 2'h2;           // Reference over selected gain
  localparam logic [23:0] BIPOLAR_MID = 24'h800000;
  localparam logic [23:0] CODE_MAX = 24'hFFFFFF;
  localparam int PROD_LSB = 23;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [25:0] GAIN_RST = 26'h1000000; // Unity for a span of 2^22
  localparam logic [23:0] ZS_RST = 24'h000000;
  localparam logic [11:0] FILTER_RST = 12'h100;
  localparam logic [2:0] GAIN_SEL_RST = 3'h0;
  localparam logic [1:0] CHAN_RST = 2'h0;

  typedef enum logic [3:0] {
    ST_NORM = 4'h1,
    ST_ZS = 4'h2,
    ST_FS = 4'h4,
    ST_POST = 4'h8
  } acs_state_t;

endpackage

// [hw/acs_rate_timer.sv]
// Purpose: Modulator-cycle and output-period tick generator.
// Assumes: Filter word is the decimal output-rate divider.
// Notes: A zero filter word is treated as one to keep ticks alive.

`timescale 1ns/1ps

module acs_rate_timer (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic restart_i,
  input wire logic [11:0] filter_word_i,
  output logic mod_tick_o,
  output logic period_tick_o
);
  import acs_pkg::*;

  logic [6:0] mod_cnt_q; // Clocks within a modulator cycle
  logic [6:0] mod_cnt_d;
  logic [11:0] per_cnt_q; // Modulator cycles within a period
  logic [11:0] per_cnt_d;
  logic [11:0] n_eff;

  // ----------------------------------------------------------------
  // Next counts and ticks
  // ----------------------------------------------------------------
  always_comb begin
    n_eff = (filter_word_i == 12'h000) ? 12'h001 : filter_word_i;
    mod_tick_o = (mod_cnt_q == MOD_CNT_MAX);
    period_tick_o = mod_tick_o && (per_cnt_q == n_eff - 12'h001); // [R23]
    mod_cnt_d = mod_cnt_q + 7'h01;
    per_cnt_d = per_cnt_q;
    if (period_tick_o) begin
      per_cnt_d = 12'h000;
    end else if (mod_tick_o) begin
      per_cnt_d = per_cnt_q + 12'h001;
    end
    // Restart aligns periods to the calibration start
    if (restart_i) begin
      mod_cnt_d = 7'h00;
      per_cnt_d = 12'h000;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mod_cnt_q <= 7'h00;
      per_cnt_q <= 12'h000;
    end else begin
      mod_cnt_q <= mod_cnt_d;
      per_cnt_q <= per_cnt_d;
    end
  end

endmodule

// [verif/acs_fe_model.sv]
// Purpose: Analog front-end stand-in driving the raw filter word.
// Assumes: Bench sets the levels before each command.
// Notes: Word follows the select one clock later.
`timescale 1ns/1ps
module acs_fe_model (
  input wire logic ref_clk_i,
  input wire logic [1:0] fe_sel_i,
  input wire logic [23:0] ext_i,
  input wire logic [23:0] bias_i,
  input wire logic [23:0] ref_i,
  output logic [23:0] raw_word_o
);
  // ----------------------------------------
  // Front end
  // ----------------------------------------
  initial raw_word_o = 24'h000000;
  // Registered, so a select change settles like a filter
  always @(posedge ref_clk_i) begin
    case (fe_sel_i)
      2'h1: raw_word_o <= bias_i; // Shorted pair at bias
      2'h2: raw_word_o <= ref_i; // Reference over gain
      2'h0: raw_word_o <= ext_i; // External pair
      default: raw_word_o <= ~raw_word_o; // Unused select gives junk
    endcase
  end
endmodule

// [verif/adc_calibration_sequencer_tb.sv]
// Purpose: Self-checking bench for the calibration sequencer.
// Assumes: Filter word 1 until the final period check, so one period is 128 clocks.
// Notes: Timing windows allow the start delay of one modulator cycle.
`timescale 1ns/1ps
module adc_calibration_sequencer_tb;
  import acs_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic wr_en_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic [23:0] raw_word_i, ext, bias, refv;
  logic [31:0] rd_data_o;
  logic data_ready_n_o, in_cal = 1'b0;
  logic [1:0] fe_sel_o, chan_sel_o;
  logic [2:0] gain_select_field_o;
  logic [3:0] fe_seen;
  int errors = 0, n_compared = 0, cyc = 0, tm = 0;
  // ----------------------------------------
  // Clock, timeout, monitors
  // ----------------------------------------
  initial forever #4 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    fe_seen <= in_cal ? (fe_seen | (4'h1 << fe_sel_o)) : 4'h0;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  acs_cal_sequencer u_acs_cal_sequencer (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .raw_word_i(raw_word_i),
    .rd_data_o(rd_data_o), .data_ready_n_o(data_ready_n_o), .fe_sel_o(fe_sel_o),
    .gain_select_field_o(gain_select_field_o), .chan_sel_o(chan_sel_o));
  acs_fe_model u_acs_fe_model (.ref_clk_i(ref_clk_i), .fe_sel_i(fe_sel_o), .ext_i(ext),
    .bias_i(bias), .ref_i(refv), .raw_word_o(raw_word_i));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out;
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_en_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_en_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(nm, e, rd_data_o);
  endtask
  task automatic win(input string nm, input int t, input int n);
    chk(nm, 32'h1, {31'h0, (t >= n * 128 - 4) && (t <= n * 128 + 140)});
  endtask
  // One calibration: start, mode clear, ready fall, data word
  task automatic run_cal(input logic [31:0] md, input int ncal, input int nrdy,
                         input logic [3:0] seen, input logic [23:0] dexp);
    int t0;
    logic [31:0] v;
    v = 32'h1;
    while (data_ready_n_o !== 1'b0 && cyc < 19000) @(negedge ref_clk_i);
    wr(ADDR_MODE, md);
    t0 = cyc;
    in_cal = 1'b1;
    // Ready is not trusted until one modulator cycle has passed
    repeat (131) @(negedge ref_clk_i);
    chk("ready high", 32'h1, {31'h0, data_ready_n_o});
    while (v[2:0] !== CAL_NORMAL && cyc - t0 < ncal * 128 + 200) begin
      @(posedge ref_clk_i);
      addr_i <= ADDR_MODE;
      rd_en_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      @(negedge ref_clk_i);
      v = rd_data_o;
    end
    win("cal time", cyc - t0, ncal);
    in_cal = 1'b0;
    chk("front ends", {28'h0, seen}, {28'h0, fe_seen});
    chk("ready held", 32'h1, {31'h0, data_ready_n_o});
    while (data_ready_n_o !== 1'b0 && cyc - t0 < nrdy * 128 + 200) @(negedge ref_clk_i);
    win("ready time", cyc - t0, nrdy);
    rchk("data", ADDR_DATA, {8'h0, dexp});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ext = 24'h000400;
    bias = 24'h000400;
    refv = 24'h200400;
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rchk("filter", ADDR_FILTER, 32'h100);
    rchk("gain rst", ADDR_GAIN_COEF, 32'h1000000);
    rchk("zs rst", ADDR_ZS_COEF, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    rchk("mode rst", ADDR_MODE, 32'h0);
    wr(ADDR_FILTER, 32'h1);
    run_cal(32'h19, 6, 9, 4'h7, 24'h000000);
    chk("gain sel", 32'h3, {29'h0, gain_select_field_o});
    rchk("zs full", ADDR_ZS_COEF, 32'h400);
    rchk("gain full", ADDR_GAIN_COEF, 32'h2000000);
    ext = 24'h200400;
    while (data_ready_n_o !== 1'b0 && cyc < 19000) @(negedge ref_clk_i);
    rchk("normal", ADDR_DATA, 32'hFFFFFF);
    // Zero scale is valid before any gain-only step
    bias = 24'h000800;
    run_cal(32'h1E, 3, 6, 4'h3, 24'hFFE000);
    rchk("zs only", ADDR_ZS_COEF, 32'h800);
    rchk("gain kept", ADDR_GAIN_COEF, 32'h2000000);
    refv = 24'h400800;
    run_cal(32'h1F, 3, 6, 4'h5, 24'h7FF000);
    rchk("zs kept", ADDR_ZS_COEF, 32'h800);
    rchk("gain only", ADDR_GAIN_COEF, 32'h1000000);
    // External level set before the command and held
    ext = 24'h000100;
    run_cal(32'h1A, 3, 4, 4'h1, 24'h000000);
    rchk("zs sys", ADDR_ZS_COEF, 32'h100);
    ext = 24'h200100;
    run_cal(32'h1B, 3, 4, 4'h1, 24'hFFFFFF);
    rchk("gain sys", ADDR_GAIN_COEF, 32'h2000000);
    ext = 24'h000100;
    run_cal(32'h11A, 3, 4, 4'h1, 24'h800000);
    wr(ADDR_MODE, 32'h84);
    rchk("code four", ADDR_MODE, 32'h80);
    chk("chan sel", 32'h2, {30'h0, chan_sel_o});
    rchk("zs chan", ADDR_ZS_COEF, 32'h0);
    // Abort right after a command: no calibration, normal words keep coming
    wr(ADDR_MODE, 32'h81);
    wr(ADDR_MODE, 32'h80);
    repeat (300) @(negedge ref_clk_i);
    chk("abort", 32'h0, {31'h0, data_ready_n_o});
    // Filter word two: one word every 256 clocks; channel 2 runs on reset coefficients
    wr(ADDR_FILTER, 32'h2);
    rchk("chan word", ADDR_DATA, 32'h400);
    while (data_ready_n_o !== 1'b0 && cyc < 19000) @(negedge ref_clk_i);
    tm = cyc;
    rchk("chan word2", ADDR_DATA, 32'h400);
    while (data_ready_n_o !== 1'b0 && cyc < 19000) @(negedge ref_clk_i);
    win("period", cyc - tm, 2);
    close_out();
  end
endmodule
